// ===== design/host_card_strobe_decode.v
`timescale 1ns/10ps
`include "card_strobe_consts.vh"

// Summary of operation
// [R1] Address bits 11-14 drive register, enables, cable select
// [R2] Chip select only when upper byte matches window
// [R3] Host drives route select high for memory mode
// [R4] Non-memory modes route strobes to I/O pair
// [R5] Memory mode routes strobes to OE/WE pair
// [R6] Route only with select low, one strobe low
// [R7] Memory read output-enable only while fixed-disk select high
// [R8] Host toggles card reset after mode switches
// [R9] Output-enable held valid at reset picks card mode
// [R10] Host treats four status bits as inputs; the code passes three (status change, activity, ready)
// [R11] Card registers decoded at four mode base addresses
// [R12] Host drives don't-care address bits as zero
// [R13] Detect contacts ORed into one presence level
// [R14] Host sets config bit then resets card
// [R15] Idle outputs stay high while deselected
module host_card_strobe_decode (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    input  wire [23:0] i_host_addr,
    input  wire        i_host_read_n,
    input  wire        i_host_store_n,
    input  wire        i_strobe_route_select,
    input  wire        i_fixed_disk_select,
    input  wire        i_card_reset_out,
    input  wire        i_mode_strap_n,
    input  wire        i_detect_contact_one_n,
    input  wire        i_detect_contact_two_n,
    input  wire        i_status_change_diag,
    input  wire        i_activity_signal,
    input  wire        i_ready_irq,
    output reg         o_host_chip_select_n,
    output reg         o_reg_space_n,
    output reg         o_card_enable_low_n,
    output reg         o_card_enable_high_n,
    output reg         o_cable_select,
    output reg         o_io_read_strobe_n,
    output reg         o_io_store_strobe_n,
    output reg         o_output_enable_n,
    output reg         o_write_enable_n,
    output reg         o_card_reset,
    output reg         o_card_present_n,
    output reg         o_status_change_in,
    output reg         o_activity_in,
    output reg         o_ready_irq_in,
    output reg         o_mode_strap_level,
    output reg [2:0]   o_reg_index,
    output reg [3:0]   o_mode_hit
);

    // Decode results ahead of the output flip-flops
    reg        next_chip_select_n;
    reg        one_strobe;
    // Routed strobe levels before registering
    reg        next_io_read_n;
    reg        next_io_store_n;
    reg        next_oe_n;
    reg        next_we_n;
    // One hit per mode register block
    wire [3:0] next_mode_hit;
    // High until the strap has been captured after reset
    reg        strap_armed;

    // Base of the eight-register block at a given address
    function [23:0] block_base;
        input [23:0] addr;
        begin
            block_base = {addr[23:3], 3'h0};
        end
    endfunction

    // Register-block base for each mode: memory, contiguous, primary, secondary
    // Don't-care address bits are expected as zero, so bases compare exactly
    function [23:0] mode_base;
        input integer mode;
        begin
            case (mode)
                0:       mode_base = `BASE_MEMORY;
                1:       mode_base = `BASE_CONTIG_IO;
                2:       mode_base = `BASE_PRIMARY_IO;
                3:       mode_base = `BASE_SECONDARY_IO;
                default: mode_base = `BASE_MEMORY;
            endcase
        end
    endfunction

    // Window decode: one compare on the upper address byte
    always @* begin
        next_chip_select_n = (i_host_addr[`WINDOW_MSB:`WINDOW_LSB] != `WINDOW_BASE); // R2
    end

    // A request counts only when exactly one host strobe is low
    always @* begin
        one_strobe = i_host_read_n ^ i_host_store_n; // R6
    end

    // Strobe routing; every card strobe idles high unless a request is routed
    // Both strobes low at once is refused rather than driving two card strobes
    always @* begin
        next_io_read_n  = `STROBE_IDLE; // R15
        next_io_store_n = `STROBE_IDLE;
        next_oe_n       = `STROBE_IDLE;
        next_we_n       = `STROBE_IDLE;
        if (!next_chip_select_n && one_strobe) begin // R6
            if (i_strobe_route_select) begin // R3
                // Memory pair; the read side also needs the fixed-disk select
                next_oe_n = i_host_read_n | ~i_fixed_disk_select; // R5 R7
                next_we_n = i_host_store_n; // R5
            end else begin
                // I/O pair for every mode other than memory
                next_io_read_n  = i_host_read_n; // R4
                next_io_store_n = i_host_store_n; // R4
            end
        end
    end

    // Register-block hits, one compare per mode, gated later by the window
    genvar mode_idx;
    generate
        for (mode_idx = 0; mode_idx < 4; mode_idx = mode_idx + 1) begin : g_mode_hit
            assign next_mode_hit[mode_idx] = block_base(i_host_addr) == mode_base(mode_idx); // R11
        end
    endgenerate

    // Chip select towards the card; idle high under reset
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_chip_select_n <= `STROBE_IDLE;
        end else begin
            o_host_chip_select_n <= next_chip_select_n; // R2
        end
    end

    // Address bits 11 to 14 onto register-space, enables and cable select
    // Bit 15 is left unused
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_space_n        <= `STROBE_IDLE;
            o_card_enable_low_n  <= `STROBE_IDLE;
            o_card_enable_high_n <= `STROBE_IDLE;
            o_cable_select       <= 1'h0;
        end else begin
            o_reg_space_n        <= i_host_addr[`BIT_REG_SPACE]; // R1
            o_card_enable_low_n  <= i_host_addr[`BIT_ENABLE_LOW]; // R1
            o_card_enable_high_n <= i_host_addr[`BIT_ENABLE_HIGH]; // R1
            o_cable_select       <= i_host_addr[`BIT_CABLE_SEL]; // R1
        end
    end

    // Card strobes; a deselected window leaves all four high
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_io_read_strobe_n   <= `STROBE_IDLE;
            o_io_store_strobe_n  <= `STROBE_IDLE;
            o_output_enable_n    <= `STROBE_IDLE;
            o_write_enable_n     <= `STROBE_IDLE;
        end else begin
            o_io_read_strobe_n   <= next_io_read_n; // R4
            o_io_store_strobe_n  <= next_io_store_n; // R4
            o_output_enable_n    <= next_oe_n; // R5
            o_write_enable_n     <= next_we_n; // R5
        end
    end

    // Card reset follows the host card-reset output, registered one clock later
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_card_reset         <= 1'h0;
        end else begin
            o_card_reset         <= i_card_reset_out; // R8
        end
    end

    // Detect contacts pull low when seated; either one open means not present
    // Registered so the host sees one clean level
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_card_present_n     <= `STROBE_IDLE;
        end else begin
            o_card_present_n     <= i_detect_contact_one_n | i_detect_contact_two_n; // R13
        end
    end

    // Card status levels back to the host pins
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status_change_in   <= 1'h0;
            o_activity_in        <= 1'h0;
            o_ready_irq_in       <= 1'h0;
        end else begin
            o_status_change_in   <= i_status_change_diag; // R10
            o_activity_in        <= i_activity_signal; // R10
            o_ready_irq_in       <= i_ready_irq; // R10
        end
    end

    // Register index and per-mode hits, both only meaningful inside the window
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_index          <= 3'h0;
            o_mode_hit           <= 4'h0;
        end else begin
            o_reg_index          <= i_host_addr[2:0];
            o_mode_hit           <= next_mode_hit & {4{~next_chip_select_n}}; // R11
        end
    end

    // Catch the output-enable strap once, at the first edge after reset release;
    // the host must hold the strap steady across reset for the card to see it
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_armed        <= 1'h1;
            o_mode_strap_level <= 1'h1;
        end else if (strap_armed) begin
            strap_armed        <= 1'h0;
            o_mode_strap_level <= i_mode_strap_n; // R9
        end
    end

endmodule // host_card_strobe_decode

// ===== design/card_strobe_consts.vh
`ifndef CARD_STROBE_CONSTS_VH
`define CARD_STROBE_CONSTS_VH

// Upper address byte that opens the 64 KB card window
`define WINDOW_BASE       8'ha8
// Host address bit positions mapped onto card pins
`define BIT_REG_SPACE     11
`define BIT_ENABLE_LOW    12
`define BIT_ENABLE_HIGH   13
`define BIT_CABLE_SEL     14
`define WINDOW_MSB        23
`define WINDOW_LSB        16
// Card register base addresses for each mode
`define BASE_MEMORY       24'ha82800
`define BASE_CONTIG_IO    24'ha82000
`define BASE_PRIMARY_IO   24'ha821f0
`define BASE_SECONDARY_IO 24'ha82170
// Reset value of every active-low card strobe and select
`define STROBE_IDLE       1'h1

`endif

// ===== verif/host_card_strobe_chk.sv
`timescale 1ns/10ps
module host_card_strobe_chk (
    input wire        i_core_clk, i_rst_n, i_host_read_n, i_host_store_n,
    input wire        i_strobe_route_select, i_fixed_disk_select,
    input wire [23:0] i_host_addr,
    input wire        o_host_chip_select_n, o_reg_space_n, o_card_enable_low_n,
    input wire        o_card_enable_high_n, o_cable_select, o_io_read_strobe_n,
    input wire        o_io_store_strobe_n, o_output_enable_n, o_write_enable_n
);
    // Host requests that should reach exactly one card strobe
    wire       sel = i_host_addr[23:16] == 8'ha8;
    wire       one = sel && (i_host_read_n ^ i_host_store_n);
    wire       ior = one && !i_strobe_route_select && !i_host_read_n;
    wire       iow = one && !i_strobe_route_select && !i_host_store_n;
    wire       oe = one && i_strobe_route_select && !i_host_read_n && i_fixed_disk_select;
    wire       we = one && i_strobe_route_select && !i_host_store_n;
    wire [3:0] pins = i_host_addr[14:11];
    wire       idle = o_io_read_strobe_n && o_io_store_strobe_n && o_output_enable_n;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    chip_sel_a: assert property (i_rst_n |=> o_host_chip_select_n == !$past(sel))
        else $error("chip select wrong");
    addr_pins_a: assert property (i_rst_n |=> {o_cable_select, o_card_enable_high_n,
        o_card_enable_low_n, o_reg_space_n} == $past(pins)) else $error("pins wrong");
    io_read_a: assert property (i_rst_n |=> o_io_read_strobe_n == !$past(ior))
        else $error("io read wrong");
    io_store_a: assert property (i_rst_n |=> o_io_store_strobe_n == !$past(iow))
        else $error("io store wrong");
    mem_read_a: assert property (i_rst_n |=> o_output_enable_n == !$past(oe))
        else $error("output enable wrong");
    mem_write_a: assert property ($rose(we) |=> $fell(o_write_enable_n))
        else $error("write enable wrong");
    one_strobe_a: assert property (!one |=> idle && o_write_enable_n)
        else $error("strobe without request");
    idle_out_a: assert property (o_host_chip_select_n |-> idle && o_write_enable_n)
        else $error("strobe while deselected");
    cover property (!o_output_enable_n);
    cover property (!o_write_enable_n);
    cover property (!o_io_store_strobe_n);
endmodule // host_card_strobe_chk
bind host_card_strobe_decode host_card_strobe_chk i_chk (.*);

// ===== verif/card_model.sv
`timescale 1ns/10ps
module card_model (
    input  wire  i_card_reset,
    input  wire  i_seat_one,
    input  wire  i_seat_two,
    output logic o_contact_one_n,
    output logic o_contact_two_n,
    output logic o_ready
);
    // Seated contacts pull low, reset holds busy
    assign o_contact_one_n = !i_seat_one;
    assign o_contact_two_n = !i_seat_two;
    assign o_ready = !i_card_reset;
endmodule // card_model

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
    logic        i_core_clk = 0, i_rst_n = 0, i_host_read_n = 1, i_host_store_n = 1;
    logic        i_strobe_route_select = 0, i_fixed_disk_select = 0, i_card_reset_out = 0;
    logic        i_mode_strap_n = 0, i_status_change_diag = 1, i_activity_signal = 1;
    logic        seat_one = 0, seat_two = 0, i_detect_contact_one_n, i_detect_contact_two_n;
    logic        i_ready_irq, o_host_chip_select_n, o_reg_space_n, o_card_enable_low_n;
    logic        o_card_enable_high_n, o_cable_select, o_io_read_strobe_n, o_io_store_strobe_n;
    logic        o_output_enable_n, o_write_enable_n, o_card_reset, o_card_present_n;
    logic        o_status_change_in, o_activity_in, o_ready_irq_in, o_mode_strap_level;
    logic [23:0] i_host_addr = 0;
    logic [2:0]  o_reg_index;
    logic [3:0]  o_mode_hit;
    int          num_errors = 0, checks_done = 0;
    host_card_strobe_decode i_host_card_strobe_decode (.*);
    card_model i_card_model (.i_card_reset(o_card_reset), .i_seat_one(seat_one),
        .i_seat_two(seat_two), .o_contact_one_n(i_detect_contact_one_n),
        .o_contact_two_n(i_detect_contact_two_n), .o_ready(i_ready_irq));
    initial forever #4 i_core_clk = ~i_core_clk;
    task automatic cmp(input string n, input logic [3:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One host access: drive at an edge, check after the next
    task automatic acc(input [23:0] a, input r, f, rd, st, input [3:0] s, h);
        @(posedge i_core_clk);
        {i_host_addr, i_strobe_route_select, i_fixed_disk_select, i_host_read_n,
            i_host_store_n} <= {a, r, f, rd, st};
        @(posedge i_core_clk);
        #1;
        cmp("strobes", s, {o_io_read_strobe_n, o_io_store_strobe_n, o_output_enable_n,
            o_write_enable_n});
        cmp("mode_hit", h, o_mode_hit);
        cmp("index", {1'b0, a[2:0]}, {1'b0, o_reg_index});
        cmp("chip_select", {3'h0, a[23:16] != 8'ha8}, {3'h0, o_host_chip_select_n});
        cmp("pins", a[14:11], {o_cable_select, o_card_enable_high_n, o_card_enable_low_n,
            o_reg_space_n});
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Reset with fixed-disk strap, then every routing case and detect
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1;
        acc(24'ha82800, 1, 1, 0, 1, 4'hd, 4'h1);
        cmp("strap", 4'h0, {3'h0, o_mode_strap_level});
        acc(24'ha82803, 1, 0, 0, 1, 4'hf, 4'h1);
        acc(24'ha82807, 1, 1, 1, 0, 4'he, 4'h1);
        acc(24'ha821f0, 0, 1, 0, 1, 4'h7, 4'h4);
        acc(24'ha82170, 0, 1, 1, 0, 4'hb, 4'h8);
        acc(24'ha82000, 0, 1, 0, 0, 4'hf, 4'h2);
        acc(24'ha82000, 1, 1, 1, 1, 4'hf, 4'h2);
        acc(24'ha92800, 1, 1, 0, 1, 4'hf, 4'h0);
        acc(24'ha84800, 1, 1, 0, 1, 4'hd, 4'h0);
        {seat_one, seat_two, i_card_reset_out} <= 3'b101;
        acc(24'h000000, 0, 0, 1, 1, 4'hf, 4'h0);
        cmp("present", 4'h1, {3'h0, o_card_present_n});
        cmp("reset", 4'h1, {3'h0, o_card_reset});
        cmp("ready", 4'h0, {3'h0, o_ready_irq_in});
        cmp("status", 4'h3, {2'h0, o_status_change_in, o_activity_in});
        {seat_two, i_card_reset_out, i_status_change_diag} <= 3'b100;
        acc(24'h000000, 0, 0, 1, 1, 4'hf, 4'h0);
        cmp("present", 4'h0, {3'h0, o_card_present_n});
        cmp("status", 4'h1, {2'h0, o_status_change_in, o_activity_in});
        give_verdict;
    end
endmodule // tb
